// *** tpm_pkg.sv ***
// three phase motor pwm: register map, field layout and mode codes
// assumes a single 200 MHz clock domain and a plain register port
package tpm_pkg;

   // ----------------------------------------------------------------
   // register offsets (word index on the plain port)
   // ----------------------------------------------------------------
   localparam logic [4:0] ADDR_START = 5'h00;
   localparam logic [4:0] ADDR_CTRL3 = 5'h01;
   localparam logic [4:0] ADDR_CTRL4 = 5'h02;
   localparam logic [4:0] ADDR_MODE3 = 5'h03;
   localparam logic [4:0] ADDR_MODE4 = 5'h04;
   localparam logic [4:0] ADDR_OUTCTL = 5'h05;
   localparam logic [4:0] ADDR_OEN = 5'h06;
   localparam logic [4:0] ADDR_BUSCTL = 5'h07;
   localparam logic [4:0] ADDR_CNT3 = 5'h08;
   localparam logic [4:0] ADDR_CNT4 = 5'h09;
   localparam logic [4:0] ADDR_LIMIT = 5'h0a;
   localparam logic [4:0] ADDR_DUTY1 = 5'h0b;
   localparam logic [4:0] ADDR_DUTY2 = 5'h0c;
   localparam logic [4:0] ADDR_DUTY3 = 5'h0d;
   localparam logic [4:0] ADDR_LIMBUF = 5'h0e;
   localparam logic [4:0] ADDR_BUF1 = 5'h0f;
   localparam logic [4:0] ADDR_BUF2 = 5'h10;
   localparam logic [4:0] ADDR_BUF3 = 5'h11;
   localparam logic [4:0] ADDR_DEAD = 5'h12;
   localparam logic [4:0] ADDR_HALF = 5'h13;
   localparam logic [4:0] ADDR_HALFBUF = 5'h14;
   localparam logic [4:0] ADDR_SUB = 5'h15;

   // ----------------------------------------------------------------
   // field positions and codes
   // ----------------------------------------------------------------
   localparam int START_PERIOD_BIT = 0;
   localparam int START_COMPANION_BIT = 1;
   localparam int BUS_ACCESS_BIT = 13;
   localparam int OUTCTL_TOGGLE_BIT = 0;
   localparam int OUTCTL_POS_BIT = 1;
   localparam int OUTCTL_NEG_BIT = 2;
   localparam logic [3:0] MODE_RESET_SYNC = 4'h8;
   localparam logic [3:0] MODE_COMP_CREST = 4'hd;
   localparam logic [3:0] MODE_COMP_TROUGH = 4'he;
   localparam logic [3:0] MODE_COMP_BOTH = 4'hf;
   localparam logic [2:0] CLEAR_ON_LIMIT = 3'h1;
   localparam logic [15:0] BUSCTL_RESET = 16'h0000;
   localparam logic [15:0] ZERO16 = 16'h0000;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [4:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } tpm_req_s;

   typedef struct packed {
      logic [2:0] clear_source_select;
      logic count_edge_select_hi;
      logic count_edge_select_lo;
      logic [2:0] prescaler_select;
   } tpm_ctrl_s;

   typedef struct packed {
      logic negative_level_select;
      logic positive_level_select;
      logic period_toggle_enable;
   } tpm_outctl_s;

endpackage

// *** tpm_core.sv ***
// three phase motor pwm: counters, compare logic and register port
// assumes registers reached over a plain strobe port, outputs go to the
// pin mux; the shutdown input is already synchronous to ref_clk_i
`timescale 1ns/100ps

// Overview of operation
// [RULE1] software halts both counters before any mode setup
// [RULE2] software selects period-limit match as the period counter clear
// [RULE3] software zeroes both counters before reset-synchronized mode
// [RULE4] duties stay at or below the limit; equal duty toggles at limit
// [RULE5] mode field 1000 selects reset-synchronized mode, phase pins output
// [RULE6] reset-synchronized: counters count up, limit match clears to zero
// [RULE7] reset-synchronized: outputs toggle on own duty match and clear
// [RULE8] software sets the period start bit to begin counting
// [RULE9] toggle-output enable plus positive and negative level selects
// [RULE10] complementary: non-overlapping pairs, toggle pin, up/down counters
// [RULE11] spare port pin stays a general port in complementary mode
// [RULE12] external shutdown input forces all pwm outputs off
// [RULE13] software loads dead time into period counter, zero in companion
// [RULE14] counters, compares, dead time, half cycle gated by bit 13
// [RULE15] buffers always accessible, temps hidden, subcounter read-only
// [RULE16] software sets limit to half cycle plus dead time, half cycle
// [RULE17] software writes identical initial duty to compare and buffer
// [RULE18] complementary mode set only in the period channel mode register
// [RULE19] master enable gates each pwm pin individually
// [RULE20] software starts both channels in one write
// [RULE21] sync clear only used for restarts from another channel
// [RULE22] software uses identical prescaler and edge on both channels
// [RULE23] complementary: period counter up to limit, down to dead time
// [RULE24] complementary: companion up to half cycle, down to zero
// [RULE25] on duty match the selected positive or negative level is driven
// [RULE26] with no pwm mode active the phase pins are not driven
module tpm_core (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [4:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic shutdown_i,
   output logic [15:0] rdata_o,
   output logic [5:0] phase_out_o,
   output logic [5:0] phase_oe_o,
   output logic period_toggle_o,
   output logic period_toggle_oe_o
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   tpm_pkg::tpm_req_s req;
   tpm_pkg::tpm_ctrl_s ctrl3;
   tpm_pkg::tpm_ctrl_s ctrl4;
   tpm_pkg::tpm_outctl_s outctl;
   logic [1:0] start;
   logic [3:0] mode3;
   logic [3:0] mode4;
   logic [5:0] oen;
   logic [15:0] busctl;
   logic [15:0] cnt3;
   logic [15:0] cnt4;
   logic [15:0] limit;
   logic [15:0] limbuf;
   logic [15:0] dead;
   logic [15:0] half;
   logic [15:0] halfbuf;
   logic [15:0] sub;
   logic [15:0] duty [3];
   logic [15:0] dbuf [3];
   logic [15:0] temp [3];
   logic [2:0] phase_st;
   logic down3;
   logic down4;
   logic prev_comp;
   logic [5:0] presc;
   logic tick;
   logic access;
   logic rs_mode;
   logic comp_mode;
   logic entering;
   logic run;
   logic rs_clear;
   logic crest;
   logic trough;
   logic xfer;
   logic [5:0] next_out;
   logic [5:0] next_oe;
   logic [5:0] mask;

   assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
   assign access = busctl[tpm_pkg::BUS_ACCESS_BIT]; // see [RULE14]
   assign rs_mode = (mode3 == tpm_pkg::MODE_RESET_SYNC); // see [RULE5]
   assign comp_mode = (mode3 == tpm_pkg::MODE_COMP_CREST) ||
      (mode3 == tpm_pkg::MODE_COMP_TROUGH) ||
      (mode3 == tpm_pkg::MODE_COMP_BOTH); // see [RULE18]
   assign entering = comp_mode && !prev_comp;
   assign run = start[tpm_pkg::START_PERIOD_BIT];
   assign rs_clear = rs_mode && tick && (cnt3 == limit) &&
      (ctrl3.clear_source_select == tpm_pkg::CLEAR_ON_LIMIT); // see [RULE6]
   assign crest = comp_mode && tick && !down3 && (cnt3 == limit);
   assign trough = comp_mode && tick && down4 && (cnt4 == tpm_pkg::ZERO16);
   assign xfer = ((mode3 != tpm_pkg::MODE_COMP_TROUGH) && crest) ||
      ((mode3 != tpm_pkg::MODE_COMP_CREST) && trough);

   // ----------------------------------------------------------------
   // prescaler
   // ----------------------------------------------------------------
   always_comb begin
      case (ctrl3.prescaler_select)
         3'h0: mask = 6'h00;
         3'h1: mask = 6'h03;
         3'h2: mask = 6'h0f;
         3'h3: mask = 6'h3f;
         default: mask = 6'h00;
      endcase
   end

   assign tick = run && ((presc & mask) == mask);

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         presc <= 6'h00;
      end else if (run) begin
         presc <= presc + 6'h01;
      end else begin
         presc <= 6'h00;
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         start <= 2'h0;
         ctrl3 <= '0;
         ctrl4 <= '0;
         mode3 <= 4'h0;
         mode4 <= 4'h0;
         outctl <= '0;
         oen <= 6'h00;
         busctl <= tpm_pkg::BUSCTL_RESET;
         prev_comp <= 1'b0;
      end else begin
         prev_comp <= comp_mode;
         if (req.wr) begin
            case (req.addr)
               tpm_pkg::ADDR_START: start <= req.wdata[1:0];
               tpm_pkg::ADDR_CTRL3: ctrl3 <= req.wdata[7:0];
               tpm_pkg::ADDR_CTRL4: ctrl4 <= req.wdata[7:0];
               tpm_pkg::ADDR_MODE3: mode3 <= req.wdata[3:0];
               tpm_pkg::ADDR_MODE4: mode4 <= req.wdata[3:0];
               tpm_pkg::ADDR_OUTCTL: outctl <= req.wdata[2:0]; // see [RULE9]
               tpm_pkg::ADDR_OEN: oen <= req.wdata[5:0]; // see [RULE19]
               tpm_pkg::ADDR_BUSCTL: busctl <= req.wdata;
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // buffers and temporaries
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         limbuf <= tpm_pkg::ZERO16;
         halfbuf <= tpm_pkg::ZERO16;
         for (int i = 0; i < 3; i++) begin
            dbuf[i] <= tpm_pkg::ZERO16;
            temp[i] <= tpm_pkg::ZERO16;
         end
      end else begin
         if (req.wr) begin // see [RULE15]
            case (req.addr)
               tpm_pkg::ADDR_LIMBUF: limbuf <= req.wdata;
               tpm_pkg::ADDR_HALFBUF: halfbuf <= req.wdata;
               tpm_pkg::ADDR_BUF1: dbuf[0] <= req.wdata;
               tpm_pkg::ADDR_BUF2: dbuf[1] <= req.wdata;
               tpm_pkg::ADDR_BUF3: dbuf[2] <= req.wdata;
               default: ;
            endcase
         end
         if (!down3) begin
            for (int i = 0; i < 3; i++) begin
               temp[i] <= dbuf[i];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // compare, limit, dead time and half cycle registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         limit <= tpm_pkg::ZERO16;
         dead <= tpm_pkg::ZERO16;
         half <= tpm_pkg::ZERO16;
         for (int i = 0; i < 3; i++) begin
            duty[i] <= tpm_pkg::ZERO16;
         end
      end else if (req.wr && access) begin // see [RULE14]
         case (req.addr)
            tpm_pkg::ADDR_LIMIT: limit <= req.wdata;
            tpm_pkg::ADDR_DEAD: dead <= req.wdata;
            tpm_pkg::ADDR_HALF: half <= req.wdata;
            tpm_pkg::ADDR_DUTY1: duty[0] <= req.wdata;
            tpm_pkg::ADDR_DUTY2: duty[1] <= req.wdata;
            tpm_pkg::ADDR_DUTY3: duty[2] <= req.wdata;
            default: ;
         endcase
      end else if (entering) begin
         limit <= limbuf;
         half <= halfbuf;
         for (int i = 0; i < 3; i++) begin
            duty[i] <= dbuf[i];
         end
      end else if (xfer) begin
         limit <= limbuf;
         half <= halfbuf;
         for (int i = 0; i < 3; i++) begin
            duty[i] <= temp[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // counters
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt3 <= tpm_pkg::ZERO16;
         down3 <= 1'b0;
      end else if (req.wr && access && req.addr == tpm_pkg::ADDR_CNT3) begin
         cnt3 <= req.wdata;
      end else if (comp_mode && !run) begin
         cnt3 <= dead;
         down3 <= 1'b0;
      end else if (rs_clear) begin
         cnt3 <= tpm_pkg::ZERO16; // see [RULE6]
      end else if (tick && rs_mode) begin
         cnt3 <= cnt3 + 16'h0001;
      end else if (tick && comp_mode) begin // see [RULE23]
         if (!down3 && cnt3 == limit) begin
            down3 <= 1'b1;
            cnt3 <= cnt3 - 16'h0001;
         end else if (down3 && cnt3 == dead) begin
            down3 <= 1'b0;
            cnt3 <= cnt3 + 16'h0001;
         end else if (down3) begin
            cnt3 <= cnt3 - 16'h0001;
         end else begin
            cnt3 <= cnt3 + 16'h0001;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt4 <= tpm_pkg::ZERO16;
         down4 <= 1'b0;
      end else if (req.wr && access && req.addr == tpm_pkg::ADDR_CNT4) begin
         cnt4 <= req.wdata;
      end else if (comp_mode && !run) begin
         down4 <= 1'b0;
      end else if (rs_clear) begin
         cnt4 <= tpm_pkg::ZERO16;
      end else if (tick && rs_mode) begin
         cnt4 <= cnt4 + 16'h0001;
      end else if (tick && comp_mode) begin // see [RULE24]
         if (!down4 && cnt4 == half) begin
            down4 <= 1'b1;
            cnt4 <= cnt4 - 16'h0001;
         end else if (down4 && cnt4 == tpm_pkg::ZERO16) begin
            down4 <= 1'b0;
            cnt4 <= cnt4 + 16'h0001;
         end else if (down4) begin
            cnt4 <= cnt4 - 16'h0001;
         end else begin
            cnt4 <= cnt4 + 16'h0001;
         end
      end
   end

   // subcounter shows the dead-time gap between the two counters
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sub <= tpm_pkg::ZERO16;
      end else if (comp_mode && run) begin
         sub <= cnt3 - cnt4; // see [RULE15]
      end else begin
         sub <= tpm_pkg::ZERO16;
      end
   end

   // ----------------------------------------------------------------
   // waveform generation
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_st <= 3'h0;
      end else if (!rs_mode) begin
         phase_st <= 3'h0;
      end else if (tick) begin
         for (int i = 0; i < 3; i++) begin
            if (cnt3 == duty[i] || rs_clear) begin // see [RULE4] [RULE7]
               phase_st[i] <= !phase_st[i];
            end
         end
      end
   end

   always_comb begin
      next_out = 6'h00;
      next_oe = 6'h00;
      for (int i = 0; i < 3; i++) begin
         if (rs_mode) begin
            next_out[2*i] = phase_st[i] ~^ outctl.positive_level_select;
            next_out[2*i+1] = phase_st[i] ^ outctl.negative_level_select;
         end else if (comp_mode) begin // see [RULE10] [RULE25]
            next_out[2*i] = (cnt4 > duty[i]) ~^
               outctl.positive_level_select;
            next_out[2*i+1] = (cnt3 < duty[i]) ~^
               outctl.negative_level_select;
         end
      end
      if ((rs_mode || comp_mode) && !shutdown_i) begin // see [RULE26]
         next_oe = oen; // see [RULE19] [RULE12]
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_out_o <= 6'h00;
         phase_oe_o <= 6'h00;
      end else begin
         phase_out_o <= next_out;
         phase_oe_o <= next_oe;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         period_toggle_o <= 1'b0;
         period_toggle_oe_o <= 1'b0;
      end else begin
         period_toggle_oe_o <= comp_mode &&
            outctl.period_toggle_enable && !shutdown_i; // see [RULE9]
         if (!comp_mode) begin
            period_toggle_o <= 1'b0;
         end else if (crest || trough) begin
            period_toggle_o <= !period_toggle_o; // see [RULE10]
         end
      end
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= tpm_pkg::ZERO16;
      end else if (req.rd) begin
         case (req.addr)
            tpm_pkg::ADDR_START: rdata_o <= {14'h0000, start};
            tpm_pkg::ADDR_CTRL3: rdata_o <= {8'h00, ctrl3};
            tpm_pkg::ADDR_CTRL4: rdata_o <= {8'h00, ctrl4};
            tpm_pkg::ADDR_MODE3: rdata_o <= {12'h000, mode3};
            tpm_pkg::ADDR_MODE4: rdata_o <= {12'h000, mode4};
            tpm_pkg::ADDR_OUTCTL: rdata_o <= {13'h0000, outctl};
            tpm_pkg::ADDR_OEN: rdata_o <= {10'h000, oen};
            tpm_pkg::ADDR_BUSCTL: rdata_o <= busctl;
            tpm_pkg::ADDR_CNT3: rdata_o <= access ? cnt3 : 16'h0000;
            tpm_pkg::ADDR_CNT4: rdata_o <= access ? cnt4 : 16'h0000;
            tpm_pkg::ADDR_LIMIT: rdata_o <= access ? limit : 16'h0000;
            tpm_pkg::ADDR_DUTY1: rdata_o <= access ? duty[0] : 16'h0000;
            tpm_pkg::ADDR_DUTY2: rdata_o <= access ? duty[1] : 16'h0000;
            tpm_pkg::ADDR_DUTY3: rdata_o <= access ? duty[2] : 16'h0000;
            tpm_pkg::ADDR_DEAD: rdata_o <= access ? dead : 16'h0000;
            tpm_pkg::ADDR_HALF: rdata_o <= access ? half : 16'h0000;
            tpm_pkg::ADDR_LIMBUF: rdata_o <= limbuf;
            tpm_pkg::ADDR_BUF1: rdata_o <= dbuf[0];
            tpm_pkg::ADDR_BUF2: rdata_o <= dbuf[1];
            tpm_pkg::ADDR_BUF3: rdata_o <= dbuf[2];
            tpm_pkg::ADDR_HALFBUF: rdata_o <= halfbuf;
            tpm_pkg::ADDR_SUB: rdata_o <= sub;
            default: rdata_o <= 16'h0000;
         endcase
      end else begin
         rdata_o <= 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence enter_s;
      comp_mode && !prev_comp && !(req.wr && access);
   endsequence

   sequence loaded_s;
      limit == $past(limbuf) && half == $past(halfbuf);
   endsequence

   rs_clear_a: assert property (rs_clear |=> cnt3 == 16'h0000) // see [RULE6]
      else $error("period counter not cleared on limit match");
   rs_up_a: assert property (tick && rs_mode && !rs_clear && !req.wr
      |=> cnt3 == $past(cnt3) + 16'h0001) // see [RULE6]
      else $error("period counter did not count up");
   rs_toggle_a: assert property (tick && rs_mode && cnt3 == duty[0]
      |=> phase_st[0] != $past(phase_st[0])) // see [RULE7]
      else $error("phase one did not toggle on duty match");
   idle_pins_a: assert property (!rs_mode && !comp_mode
      |=> phase_oe_o == 6'h00) // see [RULE26]
      else $error("phase pins driven outside pwm modes");
   shutdown_off_a: assert property (shutdown_i
      |=> phase_oe_o == 6'h00 && !period_toggle_oe_o) // see [RULE12]
      else $error("outputs still driven during shutdown");
   mode_load_a: assert property (enter_s |=> loaded_s) // see [RULE10]
      else $error("buffers not loaded on complementary entry");
   locked_read_a: assert property (req.rd && !access &&
      req.addr == tpm_pkg::ADDR_CNT3 |=> rdata_o == 16'h0000) // see [RULE14]
      else $error("counter readable while access disabled");
   buffer_write_a: assert property (req.wr &&
      req.addr == tpm_pkg::ADDR_BUF1 |=> dbuf[0] == $past(req.wdata))
      else $error("buffer write lost"); // see [RULE15]
   crest_turn_a: assert property (crest && !req.wr
      |=> down3 && cnt3 == $past(limit) - 16'h0001) // see [RULE23]
      else $error("period counter did not turn at limit");
   trough_turn_a: assert property (trough && !req.wr
      |=> !down4 && cnt4 == 16'h0001) // see [RULE24]
      else $error("companion counter did not turn at zero");

endmodule // tpm_core

// *** tpm_inverter_model.sv ***
// inverter power stage model: six gate drivers behind the phase pins
// assumes pins sampled on ref_clk_i; a released gate input pulls low
`timescale 1ns/100ps
module tpm_inverter_model (
   input wire logic ref_clk_i,
   input wire logic [5:0] phase_out_i,
   input wire logic [5:0] phase_oe_i,
   output logic [5:0] gate_o,
   output logic shoot_o
);
   // ----------------------------------------------------------------
   // gate levels, pull-down on undriven pins
   // ----------------------------------------------------------------
   assign gate_o = phase_out_i & phase_oe_i;

   // ----------------------------------------------------------------
   // both switches of one leg on together
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      shoot_o <= (gate_o[0] & gate_o[1]) | (gate_o[2] & gate_o[3]) |
         (gate_o[4] & gate_o[5]);
   end
endmodule // tpm_inverter_model

// *** tpm_tb_top.sv ***
// testbench for tpm_core: register calls with expected values
// assumes tpm_pkg and tpm_inverter_model compiled before this file
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin compares++; \
   if ((got) !== (ex)) begin n_fail++; \
   $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module tpm_tb_top;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [4:0] addr_i = 5'h00;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic shutdown_i = 1'b0;
   logic [15:0] rdata_o;
   logic [5:0] phase_out_o;
   logic [5:0] phase_oe_o;
   logic [5:0] gate;
   logic period_toggle_o;
   logic period_toggle_oe_o;
   logic shoot;
   int n_fail = 0;
   int compares = 0;

   // ----------------------------------------------------------------
   // clock, design and far side
   // ----------------------------------------------------------------
   always #2.5 ref_clk_i = ~ref_clk_i;

   tpm_core dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .shutdown_i(shutdown_i),
      .rdata_o(rdata_o), .phase_out_o(phase_out_o), .phase_oe_o(phase_oe_o),
      .period_toggle_o(period_toggle_o),
      .period_toggle_oe_o(period_toggle_oe_o));

   tpm_inverter_model stage (.ref_clk_i(ref_clk_i), .phase_out_i(phase_out_o),
      .phase_oe_i(phase_oe_o), .gate_o(gate), .shoot_o(shoot));

   // ----------------------------------------------------------------
   // bus tasks
   // ----------------------------------------------------------------
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge ref_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge ref_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask

   task automatic rd_chk(input string nm, input logic [4:0] a,
      input logic [15:0] ex);
      logic [15:0] d;
      rd(a, d);
      `CHK(nm, ex, d)
   endtask

   // counts edges of phase 1/2/3 positive and the toggle pin
   task automatic watch(input int n, output int t[4]);
      logic [6:0] prev;
      logic [6:0] cur;
      t = '{0, 0, 0, 0};
      prev = {period_toggle_o, phase_out_o};
      repeat (n) begin
         @(posedge ref_clk_i);
         #1;
         cur = {period_toggle_o, phase_out_o};
         for (int i = 0; i < 4; i++) begin
            t[i] += int'(cur[2 * i] != prev[2 * i]);
         end
         `CHK("leg overlap", 1'b0, shoot)
         prev = cur;
      end
   endtask

   task automatic complete_run;
      if (n_fail == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge ref_clk_i);
      n_fail++;
      complete_run();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [15:0] v;
      int t[4];
      logic [3:0] md[3];
      md = '{tpm_pkg::MODE_COMP_CREST, tpm_pkg::MODE_COMP_TROUGH,
         tpm_pkg::MODE_COMP_BOTH};
      repeat (12) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      rd_chk("bus control", tpm_pkg::ADDR_BUSCTL,
         tpm_pkg::BUSCTL_RESET);
      `CHK("idle oe", 6'h00, phase_oe_o)
      wr(tpm_pkg::ADDR_START, 16'h0000);
      wr(tpm_pkg::ADDR_LIMIT, 16'h0003);
      rd_chk("gated limit", tpm_pkg::ADDR_LIMIT, 16'h0000);
      wr(tpm_pkg::ADDR_LIMBUF, 16'h0003);
      rd_chk("limit buffer", tpm_pkg::ADDR_LIMBUF, 16'h0003);
      wr(tpm_pkg::ADDR_BUSCTL, 16'h2000);
      rd_chk("unmapped", 5'h1f, 16'h0000);
      wr(tpm_pkg::ADDR_CTRL3, 16'h0020);
      wr(tpm_pkg::ADDR_CNT3, 16'h0000);
      wr(tpm_pkg::ADDR_CNT4, 16'h0000);
      wr(tpm_pkg::ADDR_SUB, 16'hffff);
      rd_chk("subcounter", tpm_pkg::ADDR_SUB, 16'h0000);
      wr(tpm_pkg::ADDR_LIMIT, 16'h0003);
      rd_chk("open limit", tpm_pkg::ADDR_LIMIT, 16'h0003);
      for (int i = 0; i < 3; i++) begin
         wr(5'(tpm_pkg::ADDR_DUTY1 + i), 16'(i + 1));
      end
      wr(tpm_pkg::ADDR_OUTCTL, 16'h0006);
      wr(tpm_pkg::ADDR_OEN, 16'h003f);
      wr(tpm_pkg::ADDR_MODE3, 16'h0008);
      wr(tpm_pkg::ADDR_START, 16'h0001);
      repeat (8) @(posedge ref_clk_i);
      #1;
      `CHK("pwm oe", 6'h3f, phase_oe_o)
      watch(40, t);
      `CHK("phase1 edges", 20, t[0])
      `CHK("phase2 edges", 20, t[1])
      `CHK("phase3 edges", 10, t[2])
      repeat (4) begin
         rd(tpm_pkg::ADDR_CNT3, v);
         `CHK("count in limit", 1'b1, v <= 16'h0003)
      end
      @(posedge ref_clk_i);
      shutdown_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      #1;
      `CHK("shutdown oe", 6'h00, phase_oe_o)
      @(posedge ref_clk_i);
      shutdown_i <= 1'b0;
      wr(tpm_pkg::ADDR_OEN, 16'h0005);
      repeat (2) @(posedge ref_clk_i);
      #1;
      `CHK("master enable", 6'h05, phase_oe_o)
      wr(tpm_pkg::ADDR_OEN, 16'h003f);
      for (int i = 0; i < 3; i++) begin
         wr(5'(tpm_pkg::ADDR_DUTY1 + i), 16'(i + 4));
         wr(5'(tpm_pkg::ADDR_BUF1 + i), 16'(i + 4));
      end
      wr(tpm_pkg::ADDR_DEAD, 16'h0002);
      wr(tpm_pkg::ADDR_HALF, 16'h0008);
      wr(tpm_pkg::ADDR_HALFBUF, 16'h0008);
      wr(tpm_pkg::ADDR_LIMIT, 16'h000a);
      wr(tpm_pkg::ADDR_LIMBUF, 16'h000a);
      wr(tpm_pkg::ADDR_OUTCTL, 16'h0007);
      for (int m = 0; m < 3; m++) begin
         wr(tpm_pkg::ADDR_START, 16'h0000);
         wr(tpm_pkg::ADDR_MODE3, 16'h0000);
         wr(tpm_pkg::ADDR_CTRL3, 16'h0000);
         wr(tpm_pkg::ADDR_CTRL4, 16'h0000);
         wr(tpm_pkg::ADDR_CNT3, 16'h0002);
         wr(tpm_pkg::ADDR_CNT4, 16'h0000);
         wr(tpm_pkg::ADDR_MODE3, {12'h000, md[m]});
         rd_chk("dead start", tpm_pkg::ADDR_CNT3, 16'h0002);
         wr(tpm_pkg::ADDR_START, 16'h0003);
         repeat (10) @(posedge ref_clk_i);
         #1;
         `CHK("toggle oe", 1'b1, period_toggle_oe_o)
         watch(160, t);
         `CHK("crest trough edges", 20, t[3])
         `CHK("phase1 comp edges", 20, t[0])
         `CHK("phase2 comp edges", 20, t[1])
         `CHK("phase3 comp edges", 20, t[2])
         rd_chk("dead gap", tpm_pkg::ADDR_SUB, 16'h0002);
         repeat (3) begin
            rd(tpm_pkg::ADDR_CNT3, v);
            `CHK("period span", 1'b1, v >= 16'h2 && v <= 16'ha)
            rd(tpm_pkg::ADDR_CNT4, v);
            `CHK("companion span", 1'b1, v <= 16'h0008)
         end
      end
      complete_run();
   end
endmodule // tpm_tb_top
